//--- rtl/dsg_pkg.sv
// shared constants and carrier types for the deep-sleep clock gating block
package dsg_pkg;

    // number of gated units: pwm, adc0, watchdog
    localparam int unsigned NUM_UNITS = 3;
    // unit indices inside the enable vectors
    localparam int unsigned UNIT_PWM = 0;
    localparam int unsigned UNIT_ADC0 = 1;
    localparam int unsigned UNIT_WDOG = 2;

    // byte offsets of the registers on the wishbone slave
    localparam logic [11:0] OFS_RUN_CFG = 12'h060;
    localparam logic [11:0] OFS_RUN_GATE = 12'h100;
    localparam logic [11:0] OFS_SLEEP_GATE = 12'h110;
    localparam logic [11:0] OFS_DEEP_GATE = 12'h120;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h130;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h134;

    // bit positions inside every gating register (same layout for all three)
    localparam int unsigned POS_PWM = 20;
    localparam int unsigned POS_ADC0 = 16;
    localparam int unsigned POS_WDOG = 3;
    // auto clock gating select inside the run clock configuration register
    localparam int unsigned POS_ACG = 27;

    // writable bits and reset value of a gating register
    localparam logic [31:0] GATE_WR_MASK = 32'h0011_0008;
    localparam logic [31:0] GATE_RESET = 32'h0000_0040;
    // writable bits and reset value of the run clock configuration register
    localparam logic [31:0] CFG_WR_MASK = 32'h0800_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // status and mask reset value
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // power mode seen by the gating logic
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } dsg_mode_t;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dsg_wb_req_t;

    // classic wishbone answer from this slave
    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
        logic        err;
    } dsg_wb_rsp_t;

endpackage

//--- rtl/dsg_gate_reg.sv
// one 32-bit gating or config register with a fixed writable mask
`timescale 1ns/1ps
`default_nettype none

module dsg_gate_reg #(
    parameter logic [31:0] WR_MASK = dsg_pkg::GATE_WR_MASK,
    parameter logic [31:0] RST_VAL = dsg_pkg::GATE_RESET
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // write port, one strobe per committed bus write
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [31:0] wr_dat,
    // stored value
    output logic [31:0] q
);

    logic [31:0] lane_mask; // byte lanes enabled by sel
    logic [31:0] upd_mask; // lanes that are also writable

    // expand byte selects into a bit mask
    always_comb begin
        lane_mask = {{8{wr_sel[3]}}, {8{wr_sel[2]}}, {8{wr_sel[1]}}, {8{wr_sel[0]}}};
        upd_mask = lane_mask & WR_MASK;
    end

    // reserved bits never change, so they keep their reset value for good
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= RST_VAL; // [R3] [R4]
        end else if (wr_en) begin
            q <= (q & ~upd_mask) | (wr_dat & upd_mask); // [R11]
        end
    end

endmodule // dsg_gate_reg

`default_nettype wire

//--- rtl/dsg_gate_cell.sv
// clock enable and bus fault for one gated unit
`timescale 1ns/1ps
`default_nettype none

module dsg_gate_cell (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // this unit's bit from each gating register
    input wire logic run_bit,
    input wire logic sleep_bit,
    input wire logic deep_bit,
    // power mode and auto clock gating select
    input wire dsg_pkg::dsg_mode_t mode,
    input wire logic auto_clock_gating_select,
    // access attempt towards the unit
    input wire logic access,
    // results
    output logic clk_en_q,
    output logic fault_q
);

    logic clk_en_d; // enable chosen for the present mode

    // sleep and deep registers only count while auto gating is selected
    always_comb begin
        clk_en_d = run_bit; // [R7]
        if (auto_clock_gating_select) begin
            case (mode)
                dsg_pkg::MODE_SLEEP: clk_en_d = sleep_bit; // [R6]
                dsg_pkg::MODE_DEEP: clk_en_d = deep_bit; // [R13]
                default: clk_en_d = run_bit; // [R13]
            endcase
        end
    end

    // registered enable keeps the gate glitch free
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_en_q <= 1'b0; // [R3]
        end else begin
            clk_en_q <= clk_en_d; // [R1]
        end
    end

    // an access to an unclocked unit becomes a one-cycle fault pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= access & ~clk_en_q; // [R2]
        end
    end

endmodule // dsg_gate_cell

`default_nettype wire

//--- rtl/dsg_clock_gate.sv
// top of the deep-sleep clock gating block: wishbone slave, gating, interrupt
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] set bit clocks unit, clear bit stops it
// [R2] access to unclocked unit gives bus fault
// [R3] all gating bits reset to zero
// [R4] deep register resets to 0x00000040
// [R5] software enables every unit it needs
// [R6] separate run, sleep, deep registers, same layout
// [R7] sleep and deep registers need auto gating
// [R8] bit 20 enables pwm clock in deep
// [R9] bit 16 enables adc0 clock in deep
// [R10] bit 3 enables watchdog clock in deep
// [R11] reserved bits read only, keep values
// [R12] deep register sits at offset 0x120
// [R13] deep sleep follows deep register, run otherwise
module dsg_clock_gate (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire dsg_pkg::dsg_wb_req_t wb_req,
    output var dsg_pkg::dsg_wb_rsp_t wb_rsp,
    // power mode requests from the processor, same clock
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // gated units: access attempts, clock enables, faults
    input wire logic [2:0] unit_access,
    output logic [2:0] unit_clk_en,
    output logic [2:0] unit_fault,
    // interrupt
    output logic irq_q
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    ////////////////////////////////////////////////////////////////////////////

    logic req_new; // request not yet answered
    logic commit; // edge at which the master samples the answer
    logic hit_cfg; // run clock configuration register
    logic hit_run; // run gating register
    logic hit_sleep; // sleep gating register
    logic hit_deep; // deep-sleep gating register
    logic hit_stat; // interrupt status
    logic hit_mask; // interrupt mask
    logic mapped; // any register hit
    logic [31:0] rd_d; // read data for the current address

    // one new request per bus cycle; the answer flop guards repeats
    assign req_new = wb_req.cyc & wb_req.stb & ~wb_rsp.ack & ~wb_rsp.err;
    // writes and read side effects happen when the answer is sampled
    assign commit = wb_req.cyc & wb_req.stb & (wb_rsp.ack | wb_rsp.err);

    // full address compare, so aliases answer with an error
    always_comb begin
        hit_cfg = 1'b0;
        hit_run = 1'b0;
        hit_sleep = 1'b0;
        hit_deep = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        case (wb_req.adr)
            dsg_pkg::OFS_RUN_CFG: hit_cfg = 1'b1;
            dsg_pkg::OFS_RUN_GATE: hit_run = 1'b1;
            dsg_pkg::OFS_SLEEP_GATE: hit_sleep = 1'b1;
            dsg_pkg::OFS_DEEP_GATE: hit_deep = 1'b1; // [R12]
            dsg_pkg::OFS_IRQ_STAT: hit_stat = 1'b1;
            dsg_pkg::OFS_IRQ_MASK: hit_mask = 1'b1;
            default: hit_cfg = 1'b0;
        endcase
    end

    assign mapped = hit_cfg | hit_run | hit_sleep | hit_deep | hit_stat | hit_mask;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////////////////

    logic [31:0] cfg_q; // run clock configuration, only the acg bit is live
    logic [31:0] run_q; // gating while running
    logic [31:0] sleep_q; // gating in sleep
    logic [31:0] deep_q; // gating in deep sleep
    logic wr_commit; // committed write to a mapped register

    assign wr_commit = commit & wb_req.we & wb_rsp.ack;

    // run clock configuration register
    dsg_gate_reg #(
        .WR_MASK(dsg_pkg::CFG_WR_MASK),
        .RST_VAL(dsg_pkg::CFG_RESET)
    ) u_cfg (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_commit & hit_cfg),
        .wr_sel(wb_req.sel),
        .wr_dat(wb_req.dat),
        .q(cfg_q)
    );

    // three gating registers of one layout, one per power mode
    dsg_gate_reg u_run (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_commit & hit_run), // [R6]
        .wr_sel(wb_req.sel),
        .wr_dat(wb_req.dat),
        .q(run_q)
    );

    dsg_gate_reg u_sleep (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_commit & hit_sleep), // [R6]
        .wr_sel(wb_req.sel),
        .wr_dat(wb_req.dat),
        .q(sleep_q)
    );

    dsg_gate_reg u_deep (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_commit & hit_deep), // [R8] [R9] [R10]
        .wr_sel(wb_req.sel),
        .wr_dat(wb_req.dat),
        .q(deep_q)
    );

    logic auto_clock_gating_select; // auto clock gating select

    assign auto_clock_gating_select = cfg_q[dsg_pkg::POS_ACG];

    ////////////////////////////////////////////////////////////////////////////
    // power mode
    ////////////////////////////////////////////////////////////////////////////

    dsg_pkg::dsg_mode_t mode_q; // current mode
    dsg_pkg::dsg_mode_t mode_d; // next mode

    // deep sleep wins when both requests are high
    always_comb begin
        if (deep_sleep_req) begin
            mode_d = dsg_pkg::MODE_DEEP;
        end else if (sleep_req) begin
            mode_d = dsg_pkg::MODE_SLEEP;
        end else begin
            mode_d = dsg_pkg::MODE_RUN; // [R13]
        end
    end

    // mode register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_q <= dsg_pkg::MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-unit gating
    ////////////////////////////////////////////////////////////////////////////

    logic [2:0] run_bits; // unit bits of the run register
    logic [2:0] sleep_bits; // unit bits of the sleep register
    logic [2:0] deep_bits; // unit bits of the deep register

    // gather each unit's field from the shared layout
    assign run_bits = {run_q[dsg_pkg::POS_WDOG], run_q[dsg_pkg::POS_ADC0],
                       run_q[dsg_pkg::POS_PWM]};
    assign sleep_bits = {sleep_q[dsg_pkg::POS_WDOG], sleep_q[dsg_pkg::POS_ADC0],
                         sleep_q[dsg_pkg::POS_PWM]};
    assign deep_bits = {deep_q[dsg_pkg::POS_WDOG], deep_q[dsg_pkg::POS_ADC0],
                        deep_q[dsg_pkg::POS_PWM]}; // [R8] [R9] [R10]

    // one cell per unit
    for (genvar gi = 0; gi < 3; gi++) begin : g_unit
        dsg_gate_cell u_cell (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .run_bit(run_bits[gi]),
            .sleep_bit(sleep_bits[gi]),
            .deep_bit(deep_bits[gi]),
            .mode(mode_q),
            .auto_clock_gating_select(auto_clock_gating_select), // [R7]
            .access(unit_access[gi]),
            .clk_en_q(unit_clk_en[gi]), // [R1]
            .fault_q(unit_fault[gi]) // [R2]
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt
    ////////////////////////////////////////////////////////////////////////////

    logic [2:0] stat_q; // sticky fault flags, one per unit
    logic [2:0] mask_q; // interrupt enables, same layout
    logic [2:0] stat_clr; // bits that the committed status read returned

    // only bits that software actually saw are cleared
    assign stat_clr = (commit & ~wb_req.we & hit_stat) ? wb_rsp.dat[2:0] : 3'h0;

    // a fault in the clearing cycle survives: set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stat_q <= dsg_pkg::IRQ_RESET;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | unit_fault;
        end
    end

    // mask register, low byte lane only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mask_q <= dsg_pkg::IRQ_RESET;
        end else if (wr_commit & hit_mask & wb_req.sel[0]) begin
            mask_q <= wb_req.dat[2:0];
        end
    end

    // level output, one cycle behind the flags
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and answer
    ////////////////////////////////////////////////////////////////////////////

    // unmapped reads never reach the bus, the error flop answers instead
    always_comb begin
        rd_d = 32'h0;
        if (hit_cfg) begin
            rd_d = cfg_q;
        end else if (hit_run) begin
            rd_d = run_q;
        end else if (hit_sleep) begin
            rd_d = sleep_q;
        end else if (hit_deep) begin
            rd_d = deep_q; // [R12] [R11]
        end else if (hit_stat) begin
            rd_d = {29'h0, stat_q};
        end else if (hit_mask) begin
            rd_d = {29'h0, mask_q};
        end
    end

    // answer one cycle after the request, held for exactly one cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_rsp <= '0;
        end else begin
            wb_rsp.ack <= req_new & mapped;
            wb_rsp.err <= req_new & ~mapped;
            if (req_new) begin
                wb_rsp.dat <= wb_req.we ? 32'h0 : rd_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////////

    default clocking dsg_cb @(posedge core_clk);
    endclocking

    default disable iff (sys_rst);

    // deep register holds its reset word straight after reset
    a_deep_reset_word: assert property ( // [R4]
        $past(sys_rst) |-> deep_q == 32'h0000_0040)
        else $error("deep gating register reset value wrong");

    // no unit is clocked just after reset
    a_units_reset_off: assert property ( // [R3]
        $past(sys_rst) |-> unit_clk_en == 3'h0)
        else $error("unit clocked after reset");

    // reserved bits never move in any gating register
    a_reserved_bits_fixed: assert property ( // [R11]
        ((deep_q | run_q | sleep_q) & ~dsg_pkg::GATE_WR_MASK) == 32'h0000_0040)
        else $error("reserved gating bit changed");

    // without auto gating the run register governs every mode
    a_run_when_no_acg: assert property ( // [R7]
        !auto_clock_gating_select |=> unit_clk_en == $past(run_bits))
        else $error("enable not from run register");

    // sleep register governs in sleep with auto gating
    a_sleep_follows_reg: assert property ( // [R6]
        auto_clock_gating_select && mode_q == dsg_pkg::MODE_SLEEP |=> unit_clk_en == $past(sleep_bits))
        else $error("enable not from sleep register");

    // deep register governs in deep sleep with auto gating
    a_deep_follows_reg: assert property ( // [R13]
        auto_clock_gating_select && mode_q == dsg_pkg::MODE_DEEP |=> unit_clk_en == $past(deep_bits))
        else $error("enable not from deep register");

    // unclocked access gives a fault on the next cycle, clocked one does not
    a_fault_on_gated: assert property ( // [R2]
        unit_access[0] |=> unit_fault[0] == !$past(unit_clk_en[0]))
        else $error("fault does not match gate state");

    // a full write of the deep register lands in the three unit bits
    a_deep_bits_write: assert property ( // [R8] [R9] [R10]
        wr_commit && hit_deep && wb_req.sel == 4'hf
        |=> deep_bits == {$past(wb_req.dat[3]), $past(wb_req.dat[16]),
                          $past(wb_req.dat[20])})
        else $error("deep unit bits not written");

    // a read at offset 0x120 returns the deep register one cycle later
    a_deep_read_addr: assert property ( // [R12]
        req_new && !wb_req.we && wb_req.adr == 12'h120
        |=> wb_rsp.ack && wb_rsp.dat == $past(deep_q))
        else $error("deep register read wrong");

    // a set watchdog bit in the run register clocks the unit on the next cycle
    a_set_bit_clocks: assert property ( // [R1]
        !auto_clock_gating_select && run_bits[2] ##1 !auto_clock_gating_select |-> unit_clk_en[2])
        else $error("set bit did not clock unit");

    // a clocked unit's access never faults, a gated one always does
    a_fault_clocked_unit: assert property ( // [R2]
        unit_access[2] |=> unit_fault[2] == !$past(unit_clk_en[2]))
        else $error("watchdog fault does not match gate state");

    // a fault pulse always lands in status, even in a clearing read
    a_stat_set_wins: assert property ( // [R2]
        |unit_fault |=> (stat_q & $past(unit_fault)) == $past(unit_fault))
        else $error("fault lost from status");

    // an unmasked status bit raises the interrupt one cycle later
    a_irq_level: assert property ( // [R2]
        |(stat_q & mask_q) |=> irq_q)
        else $error("interrupt not raised");

    // an address outside the map is answered with an error, never an ack
    a_unmapped_err: assert property ( // [R12]
        req_new && !mapped |=> wb_rsp.err && !wb_rsp.ack)
        else $error("unmapped access not refused");

endmodule // dsg_clock_gate

`default_nettype wire

//--- testbench/dsg_unit_model.sv
// partner model: gated units that try bus accesses and log what the block answers
`timescale 1ns/1ps
`default_nettype none

module dsg_unit_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // access attempts asked for by the bench, one bit per unit, and the fault log clear
    input wire logic [2:0] try_req,
    input wire logic seen_clr,
    // block side
    input wire logic [2:0] clk_en,
    input wire logic [2:0] fault,
    output logic [2:0] access_q,
    // sticky logs for the bench
    output logic [2:0] seen_q,
    output logic [2:0] ran_q
);
    // a unit tries its access in the cycle after the bench asks
    always_ff @(posedge core_clk) begin
        access_q <= sys_rst ? 3'h0 : try_req;
    end
    // faults are one-cycle pulses, so log them sticky or the bench could miss one
    always_ff @(posedge core_clk) begin
        seen_q <= (sys_rst || seen_clr) ? 3'h0 : (seen_q | fault);
    end
    // a unit only runs while its clock is enabled
    always_ff @(posedge core_clk) begin
        ran_q <= sys_rst ? 3'h0 : (ran_q | clk_en);
    end
endmodule // dsg_unit_model

`default_nettype wire

//--- testbench/dsg_clock_gate_bench.sv
// self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none

module dsg_clock_gate_bench;
    // clock, reset and block ports
    logic core_clk;
    logic sys_rst;
    dsg_pkg::dsg_wb_req_t wb_req;
    dsg_pkg::dsg_wb_rsp_t wb_rsp;
    logic sleep_req;
    logic deep_sleep_req;
    logic [2:0] unit_access;
    logic [2:0] unit_clk_en;
    logic [2:0] unit_fault;
    logic irq_q;
    // partner control and logs
    logic [2:0] try_req;
    logic seen_clr;
    logic [2:0] seen_q;
    logic [2:0] ran_q;
    // verdict counters
    int fail_count;
    int n_compared;

    dsg_clock_gate dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault),
        .irq_q(irq_q));
    dsg_unit_model units (.core_clk(core_clk), .sys_rst(sys_rst), .try_req(try_req),
        .seen_clr(seen_clr), .clk_en(unit_clk_en), .fault(unit_fault),
        .access_q(unit_access), .seen_q(seen_q), .ran_q(ran_q));

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // compare one value, report and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one classic wishbone cycle; waits for ack or err under a bounded count
    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
            input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_req <= {1'b1, 1'b1, we, adr, sel, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1 && n < 40);
        rd = wb_rsp.dat;
        er = wb_rsp.err;
        if (n >= 40) begin
            fail_count++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        wb_req <= '0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        wb_xfer(1'b1, adr, 4'hf, wd, d, e);
    endtask

    task automatic rd(input logic [11:0] adr, output logic [31:0] d);
        logic e;
        wb_xfer(1'b0, adr, 4'hf, 32'h0, d, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reset values, offsets and the unmapped hole
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0000_0040);
        rd(dsg_pkg::OFS_RUN_GATE, d);
        chk(d, 32'h0000_0040);
        rd(dsg_pkg::OFS_SLEEP_GATE, d);
        chk(d, 32'h0000_0040);
        chk(unit_clk_en, 32'h0);
        wb_xfer(1'b1, 12'h124, 4'hf, 32'hffff_ffff, d, e);
        chk(e, 32'h1);
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0000_0040);
    endtask

    // writable fields, read-only reserved bits and byte lanes
    task automatic t_fields();
        logic [31:0] d;
        logic e;
        wr(dsg_pkg::OFS_DEEP_GATE, 32'hffff_ffff);
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0011_0048);
        wb_xfer(1'b1, dsg_pkg::OFS_DEEP_GATE, 4'h1, 32'h0, d, e);
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0011_0040);
        wb_xfer(1'b1, dsg_pkg::OFS_DEEP_GATE, 4'h4, 32'h0, d, e);
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0000_0040);
        // read-modify-write keeps the reserved read values
        wr(dsg_pkg::OFS_DEEP_GATE, d | 32'h0011_0000);
        rd(dsg_pkg::OFS_DEEP_GATE, d);
        chk(d, 32'h0011_0040);
    endtask

    // register selection by power mode and auto gating
    task automatic t_modes();
        logic [31:0] d;
        wr(dsg_pkg::OFS_RUN_GATE, 32'h0000_0048);
        cyc_wait(3);
        chk(unit_clk_en, 32'h4);
        deep_sleep_req <= 1'b1;
        cyc_wait(4);
        chk(unit_clk_en, 32'h4);
        wr(dsg_pkg::OFS_RUN_CFG, 32'hffff_ffff);
        rd(dsg_pkg::OFS_RUN_CFG, d);
        chk(d, 32'h0800_0000);
        cyc_wait(3);
        chk(unit_clk_en, 32'h3);
        deep_sleep_req <= 1'b0;
        sleep_req <= 1'b1;
        cyc_wait(4);
        chk(unit_clk_en, 32'h0);
        sleep_req <= 1'b0;
        cyc_wait(4);
        chk(unit_clk_en, 32'h4);
        chk(ran_q, 32'h7);
    endtask

    // faults towards unclocked units, sticky status, mask and interrupt
    task automatic t_faults();
        logic [31:0] d;
        wr(dsg_pkg::OFS_IRQ_MASK, 32'h7);
        try_req <= 3'h5;
        @(posedge core_clk);
        try_req <= 3'h0;
        cyc_wait(6);
        chk(seen_q, 32'h1);
        chk(irq_q, 32'h1);
        rd(dsg_pkg::OFS_IRQ_STAT, d);
        chk(d, 32'h1);
        rd(dsg_pkg::OFS_IRQ_STAT, d);
        chk(d, 32'h0);
        cyc_wait(2);
        chk(irq_q, 32'h0);
        // masked event still lands in status but keeps the line low
        wr(dsg_pkg::OFS_IRQ_MASK, 32'h0);
        try_req <= 3'h2;
        seen_clr <= 1'b1;
        @(posedge core_clk);
        try_req <= 3'h0;
        seen_clr <= 1'b0;
        cyc_wait(6);
        chk(seen_q, 32'h2);
        chk(irq_q, 32'h0);
        rd(dsg_pkg::OFS_IRQ_STAT, d);
        chk(d, 32'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fail_count = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        wb_req = '0;
        sleep_req = 1'b0;
        deep_sleep_req = 1'b0;
        try_req = 3'h0;
        seen_clr = 1'b0;
        cyc_wait(12);
        sys_rst <= 1'b0;
        cyc_wait(1);
        t_reset();
        t_fields();
        t_modes();
        t_faults();
        report_and_stop();
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule // dsg_clock_gate_bench

`default_nettype wire
